// ---- rtl/pab_bridge.sv ----
`timescale 1ns/1ps
`include "pab_consts.svh"
module pab_bridge #(
  parameter logic [12:0] REGISTER_WINDOW_BASE = 13'h0000,
  parameter bit EN_MAP_CSR = 1'b0,
  parameter bit EN_DMA = 1'b0,
  parameter int IDX_W = 10
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic apb_preset_n,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rx_valid,
  input wire pab_pkg::pab_rx_t rx_word,
  output logic rx_ready,
  output logic tx_valid,
  output pab_pkg::pab_tx_t tx_word,
  input wire logic tx_ready,
  output logic creg_req,
  output pab_pkg::pab_creg_t creg_cmd,
  input wire logic creg_ack,
  input wire logic creg_err,
  input wire logic [31:0] creg_rdata,
  output pab_pkg::pab_ahbm_t m_w_out,
  input wire pab_pkg::pab_ahbm_in_t m_w_in,
  output pab_pkg::pab_ahbm_t m_r_out,
  input wire pab_pkg::pab_ahbm_in_t m_r_in,
  input wire pab_pkg::pab_ahbs_in_t s_in,
  output logic [31:0] s_hrdata,
  output logic s_hready,
  output logic s_hresp,
  input wire pab_pkg::pab_apb_in_t ap_in,
  output logic [31:0] ap_prdata,
  output logic ap_pready,
  output logic ap_pslverr
);
  import pab_pkg::*;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic addr_ok(input logic [31:0] a, input logic regs_on);
    logic ok;
    ok = (a[31:19] == REGISTER_WINDOW_BASE) && (a[1:0] == 2'h0);
    case (a[18:16])
      `PAB_RGN_LINK: ok = ok && regs_on;
      `PAB_RGN_PHY: ok = ok && regs_on && (a[15:8] == 8'h00);
      `PAB_RGN_CFG: ok = ok && regs_on && (a[15:14] == 2'h0);
      `PAB_RGN_TX: ok = ok && !regs_on && (a[15:12] == 4'h0);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic pab_creg_t creg_build(input logic [31:0] a, input logic wr,
                                           input logic [31:0] wd);
    pab_creg_t c;
    c.wr = wr;
    c.rgn = a[17:16];
    c.func = 2'h0;
    c.off = a[15:2];
    c.wdata = wd;
    if (a[18:16] == `PAB_RGN_CFG)
    begin
      c.func = a[13:12];
      c.off = {4'h0, a[11:2]};
    end
    else if (a[18:16] == `PAB_RGN_PHY)
      c.off = {8'h00, a[7:2]};
    return c;
  endfunction

  logic [31:0] base_rxp_q;
  logic [31:0] base_rxn_q;
  logic [31:0] base_rxc_q;

  function automatic logic [31:0] base_of(input logic [1:0] kind);
    return (kind == `PAB_KIND_NP) ? base_rxn_q :
           (kind == `PAB_KIND_CPL) ? base_rxc_q : base_rxp_q;
  endfunction

  // ---------------------------------------------------------------
  // Local registers
  // ---------------------------------------------------------------
  logic [15:0] rx_pkts_q;
  logic [15:0] tx_pkts_q;
  logic [7:0] m_err_q;

  // Bases: low bits forced to zero so a packet never straddles a 4KB page
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      base_rxp_q <= `PAB_RX_BASE_RST;
      base_rxn_q <= `PAB_RX_BASE_RST;
      base_rxc_q <= `PAB_RX_BASE_RST;
    end
    else if (ce && reg_wr)
    begin
      case (reg_addr)
        `PAB_REG_RXP: base_rxp_q <= {reg_wdata[31:`PAB_ALIGN_LSB], 12'h000};
        `PAB_REG_RXN: base_rxn_q <= {reg_wdata[31:`PAB_ALIGN_LSB], 12'h000};
        `PAB_REG_RXC: base_rxc_q <= {reg_wdata[31:`PAB_ALIGN_LSB], 12'h000};
        default: ;
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 32'h0;
    else if (ce)
    begin
      reg_rdata <= 32'h0;
      if (reg_rd)
        case (reg_addr)
          `PAB_REG_RXP: reg_rdata <= base_rxp_q;
          `PAB_REG_RXN: reg_rdata <= base_rxn_q;
          `PAB_REG_RXC: reg_rdata <= base_rxc_q;
          `PAB_REG_STAT: reg_rdata <= {rx_pkts_q, tx_pkts_q};
          `PAB_REG_ERR: reg_rdata <= {24'h0, m_err_q};
          default: reg_rdata <= 32'h0;
        endcase
    end
  end

  // ---------------------------------------------------------------
  // Receive path: buffer then AHB write master
  // ---------------------------------------------------------------
  pab_mst_t mst_q;
  pab_rx_t rxb_word;
  logic rxb_valid;
  logic [IDX_W-1:0] idx_q;

  pab_buf2 #(.W($bits(pab_rx_t))) u_rxbuf (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .in_valid(rx_valid),
    .in_data(rx_word),
    .in_ready(rx_ready),
    .out_valid(rxb_valid),
    .out_data(rxb_word),
    .out_ready(mst_q == M_IDLE)
  );

  // One single write per dword; BUSY and SEQ never used, trading speed for simplicity
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mst_q <= M_IDLE;
      idx_q <= '0;
      rx_pkts_q <= 16'h0;
      m_err_q <= 8'h0;
      m_w_out <= '0;
      m_w_out.hprot <= `PAB_PROT;
      m_w_out.hsize <= `PAB_SIZE_WORD;
      m_w_out.hwrite <= 1'b1;
    end
    else if (ce)
    begin
      m_w_out.hmastlock <= 1'b0;
      m_w_out.hprot <= `PAB_PROT;
      m_w_out.hburst <= `PAB_BURST_SINGLE;
      unique case (mst_q)
        M_IDLE:
          if (rxb_valid)
          begin
            m_w_out.haddr <= base_of(rxb_word.kind) + {20'h0, idx_q, 2'h0};
            m_w_out.htrans <= `PAB_TRANS_NSEQ;
            m_w_out.hwdata <= rxb_word.data;
            idx_q <= rxb_word.last ? '0 : idx_q + 1'b1;
            if (rxb_word.last)
              rx_pkts_q <= rx_pkts_q + 16'h1;
            mst_q <= M_ADDR;
          end
        M_ADDR:
          if (m_w_in.hready)
          begin
            m_w_out.htrans <= `PAB_TRANS_IDLE;
            mst_q <= M_DATA;
          end
        M_DATA:
          if (m_w_in.hready)
          begin
            if (m_w_in.hresp)
              m_err_q <= m_err_q + 8'h1;
            mst_q <= M_IDLE;
          end
      endcase
    end
  end

  // Read master stays idle in every mode; there is no DMA master
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      m_r_out <= '0;
      m_r_out.hprot <= `PAB_PROT;
      m_r_out.hsize <= `PAB_SIZE_WORD;
    end
    else if (ce)
      m_r_out.htrans <= `PAB_TRANS_IDLE;
  end

  // ---------------------------------------------------------------
  // Data slave: transmit words and mapped registers
  // ---------------------------------------------------------------
  pab_slv_t sl_q;
  logic [31:0] sl_addr_q;
  logic sl_wr_q;
  logic txb_ready;
  logic accept;
  logic creg_busy_q;
  pab_tx_t txb_in;

  assign accept = s_in.hsel && s_in.hreadyin && s_in.htrans[1] && s_hready;
  assign txb_in.sop = (sl_addr_q[11:2] == 10'h000);
  assign txb_in.data = s_in.hwdata;

  pab_buf2 #(.W($bits(pab_tx_t))) u_txbuf (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .in_valid(sl_q == SL_PUSH),
    .in_data(txb_in),
    .in_ready(txb_ready),
    .out_valid(tx_valid),
    .out_data(tx_word),
    .out_ready(tx_ready)
  );

  // Every accepted write holds at least one wait state, so ready stays a flop
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sl_q <= SL_READY;
      s_hready <= 1'b1;
      s_hresp <= 1'b0;
      s_hrdata <= 32'h0;
      sl_addr_q <= 32'h0;
      sl_wr_q <= 1'b0;
      tx_pkts_q <= 16'h0;
    end
    else if (ce)
    begin
      unique case (sl_q)
        SL_READY:
        begin
          s_hresp <= 1'b0;
          if (accept)
          begin
            sl_addr_q <= s_in.haddr;
            sl_wr_q <= s_in.hwrite;
            s_hrdata <= 32'h0;
            if (EN_DMA || !addr_ok(s_in.haddr, EN_MAP_CSR))
            begin
              s_hready <= 1'b0;
              s_hresp <= 1'b1;
              sl_q <= SL_ERR;
            end
            else if (s_in.haddr[18:16] == `PAB_RGN_TX)
            begin
              s_hready <= !s_in.hwrite;
              sl_q <= s_in.hwrite ? SL_PUSH : SL_READY;
            end
            else
            begin
              s_hready <= 1'b0;
              sl_q <= SL_CREG;
            end
          end
        end
        SL_PUSH:
          if (txb_ready)
          begin
            if (txb_in.sop)
              tx_pkts_q <= tx_pkts_q + 16'h1;
            s_hready <= 1'b1;
            sl_q <= SL_READY;
          end
        SL_ERR:
        begin
          s_hready <= 1'b1;
          sl_q <= SL_READY;
        end
        SL_CREG:
          if (creg_busy_q && creg_ack)
          begin
            s_hrdata <= creg_rdata;
            s_hresp <= creg_err;
            s_hready <= !creg_err;
            sl_q <= creg_err ? SL_ERR : SL_READY;
          end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // APB configuration port
  // ---------------------------------------------------------------
  pab_apb_t ap_q;
  logic [31:0] ap_addr_q;
  logic ap_wr_q;

  // asynchronous assertion; release is not synchronized to clk here
  always_ff @(posedge clk or negedge apb_preset_n)
  begin
    if (!apb_preset_n)
    begin
      ap_q <= AP_IDLE;
      ap_pready <= 1'b0;
      ap_pslverr <= 1'b0;
      ap_prdata <= 32'h0;
      ap_addr_q <= 32'h0;
      ap_wr_q <= 1'b0;
    end
    else if (ce)
    begin
      ap_pready <= 1'b0;
      ap_pslverr <= 1'b0;
      unique case (ap_q)
        AP_IDLE:
          if (ap_in.psel && !ap_in.penable)
          begin
            ap_addr_q <= ap_in.paddr;
            ap_wr_q <= ap_in.pwrite;
            ap_prdata <= 32'h0;
            // error completes in first access cycle
            if (!addr_ok(ap_in.paddr, !EN_MAP_CSR) || EN_MAP_CSR)
            begin
              ap_pready <= 1'b1;
              ap_pslverr <= 1'b1;
            end
            else
              ap_q <= AP_WAIT;
          end
        AP_WAIT:
          if (creg_busy_q && creg_ack)
          begin
            ap_prdata <= creg_rdata;
            ap_pready <= 1'b1;
            ap_pslverr <= creg_err;
            ap_q <= AP_IDLE;
          end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Core register request, owned by whichever port is enabled
  // ---------------------------------------------------------------
  logic creg_start;
  assign creg_start = !creg_busy_q && (EN_MAP_CSR ? (sl_q == SL_CREG) : (ap_q == AP_WAIT));

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      creg_req <= 1'b0;
      creg_busy_q <= 1'b0;
      creg_cmd <= '0;
    end
    else if (ce)
    begin
      creg_req <= creg_start;
      if (creg_start)
      begin
        creg_busy_q <= 1'b1;
        creg_cmd <= EN_MAP_CSR ? creg_build(sl_addr_q, sl_wr_q, s_in.hwdata) :
                                 creg_build(ap_addr_q, ap_wr_q, ap_in.pwdata);
      end
      else if (creg_ack)
        creg_busy_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [31:0] exp_addr_q;
  logic new_pkt_q;
  logic issue;
  assign issue = (m_w_out.htrans == `PAB_TRANS_NSEQ) && (mst_q == M_ADDR);

  // Expected next address, tracked apart from the master
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      exp_addr_q <= 32'h0;
      new_pkt_q <= 1'b1;
    end
    else if (ce && rxb_valid && mst_q == M_IDLE)
    begin
      exp_addr_q <= m_w_out.haddr + 32'h4;
      new_pkt_q <= rxb_word.last;
    end
  end

  sequence s_err_first;
    s_hresp && !s_hready;
  endsequence
  sequence s_apb_bad;
    ap_in.psel && !ap_in.penable && ap_q == AP_IDLE && !addr_ok(ap_in.paddr, !EN_MAP_CSR);
  endsequence

  lock_prot_a: assert property (@(posedge clk) disable iff (reset)
    !m_w_out.hmastlock && m_w_out.hprot == 4'h3 && m_r_out.hprot == 4'h3)
    else $error("master lock or protection wrong");
  burst_size_a: assert property (@(posedge clk) disable iff (reset)
    m_w_out.hburst == 3'h0 && m_w_out.hsize == 3'h2)
    else $error("master burst or size wrong");
  rx_step_a: assert property (@(posedge clk) disable iff (reset)
    $rose(issue) && !$past(new_pkt_q) |-> m_w_out.haddr == exp_addr_q)
    else $error("receive address did not advance by one dword");
  rx_base_a: assert property (@(posedge clk) disable iff (reset)
    $rose(issue) && $past(new_pkt_q) |-> m_w_out.haddr[11:0] == 12'h000)
    else $error("packet did not start on its base");
  err_resp_a: assert property (@(posedge clk) disable iff (reset)
    s_err_first |=> s_hresp && s_hready)
    else $error("error response not two cycles");
  tx_push_a: assert property (@(posedge clk) disable iff (reset)
    sl_q == SL_PUSH |-> sl_addr_q[18:12] == 7'h30 && !s_hready)
    else $error("transmit push outside its region");
  apb_err_a: assert property (@(posedge clk) disable iff (!apb_preset_n || !ce)
    s_apb_bad |=> ap_pready && ap_pslverr)
    else $error("apb error not flagged in completing cycle");
  creg_rgn_a: assert property (@(posedge clk) disable iff (reset)
    creg_req |-> creg_cmd.rgn != 2'h3 && creg_busy_q)
    else $error("core request to transmit region");
  cfg_off_a: assert property (@(posedge clk) disable iff (reset)
    creg_req && creg_cmd.rgn == 2'h2 |-> creg_cmd.off[13:10] == 4'h0)
    else $error("config offset too wide");
endmodule

// ---- rtl/pab_consts.svh ----
`ifndef PAB_CONSTS_SVH
`define PAB_CONSTS_SVH
// Overview of operation
// - Received dwords written from type base upward
// - Transmit index bits zero restart each header
// - Window base, link and PHY region decode
// - Config region: function and register offset
// - Optionally serve registers over data slave
// - DMA mode: data slave errors every access; read master stays idle
// - Little-endian byte order on all ports
// - Master lock low, protection 4'b0011
// - Bursts limited to single or incrementing
// - APB reset active low, asynchronous assert
// - APB may stretch; error in completing cycle

// ---------------------------------------------------------------
// Local register map and reset values
// ---------------------------------------------------------------
`define PAB_REG_RXP 5'h00
`define PAB_REG_RXN 5'h04
`define PAB_REG_RXC 5'h08
`define PAB_REG_STAT 5'h0c
`define PAB_REG_ERR 5'h10
`define PAB_RX_BASE_RST 32'h0000_0000
`define PAB_ALIGN_LSB 12

// ---------------------------------------------------------------
// Window regions and bus encodings
// ---------------------------------------------------------------
`define PAB_RGN_LINK 3'h0
`define PAB_RGN_PHY 3'h1
`define PAB_RGN_CFG 3'h2
`define PAB_RGN_TX 3'h3
`define PAB_PROT 4'h3
`define PAB_SIZE_WORD 3'h2
`define PAB_BURST_SINGLE 3'h0
`define PAB_TRANS_IDLE 2'h0
`define PAB_TRANS_NSEQ 2'h2
`define PAB_KIND_NP 2'h1
`define PAB_KIND_CPL 2'h2
`endif

// ---- rtl/pab_pkg.sv ----
package pab_pkg;
  // Receive word: last flag, type (0 posted, 1 non-posted, 2 completion)
  typedef struct packed {logic last; logic [1:0] kind; logic [31:0] data;} pab_rx_t;
  typedef struct packed {logic sop; logic [31:0] data;} pab_tx_t;
  // Core register request toward link, PHY or config space
  typedef struct packed {
    logic wr;
    logic [1:0] rgn;
    logic [1:0] func;
    logic [13:0] off;
    logic [31:0] wdata;
  } pab_creg_t;
  typedef struct packed {
    logic [31:0] haddr;
    logic [2:0] hburst;
    logic hmastlock;
    logic [3:0] hprot;
    logic [2:0] hsize;
    logic [1:0] htrans;
    logic [31:0] hwdata;
    logic hwrite;
  } pab_ahbm_t;
  typedef struct packed {logic [31:0] hrdata; logic hready; logic hresp;} pab_ahbm_in_t;
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [2:0] hburst;
    logic hmastlock;
    logic [3:0] hprot;
    logic [2:0] hsize;
    logic [1:0] htrans;
    logic [31:0] hwdata;
    logic hwrite;
    logic hreadyin;
  } pab_ahbs_in_t;
  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } pab_apb_in_t;
  typedef enum logic [2:0] {M_IDLE = 3'b001, M_ADDR = 3'b010, M_DATA = 3'b100} pab_mst_t;
  typedef enum logic [3:0] {
    SL_READY = 4'b0001,
    SL_PUSH = 4'b0010,
    SL_CREG = 4'b0100,
    SL_ERR = 4'b1000
  } pab_slv_t;
  typedef enum logic [1:0] {AP_IDLE = 2'b01, AP_WAIT = 2'b10} pab_apb_t;
endpackage

// ---- rtl/pab_buf2.sv ----
`timescale 1ns/1ps
module pab_buf2 #(
  parameter int W = 33
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [W-1:0] spare_q;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Occupancy after this cycle
  always_comb
  begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + 2'h1;
    else if (pop && !push)
      cnt_d = cnt_q - 2'h1;
  end

  // Ready and valid registered, so a stall never reaches a port combinationally
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_q <= 2'h0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != 2'h2);
      out_valid <= (cnt_d != 2'h0);
    end
  end

  // Head slot and spare slot
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      out_data <= '0;
      spare_q <= '0;
    end
    else if (ce)
    begin
      if (pop && cnt_q == 2'h2)
        out_data <= spare_q;
      else if (push && (cnt_q == 2'h0 || (pop && cnt_q == 2'h1)))
        out_data <= in_data;
      if (push && (cnt_q == 2'h2 || (cnt_q == 2'h1 && !pop)))
        spare_q <= in_data;
    end
  end
endmodule

// ---- test/pab_ahb_sink.sv ----
`timescale 1ns/1ps
module pab_ahb_sink (
  input wire logic clk,
  input wire logic reset,
  input wire logic stall,
  input wire pab_pkg::pab_ahbm_t m_out,
  output pab_pkg::pab_ahbm_in_t m_in,
  output logic wr_seen,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data
);
  import pab_pkg::*;
  logic dphase_q;
  logic [31:0] addr_q;
  logic [31:0] cnt_q;
  // ----------------------------------------
  // Write sink with wait states
  // ----------------------------------------
  // Read data is never used, so it moves every cycle
  assign m_in = '{hrdata: cnt_q, hready: ~stall, hresp: 1'b0};
  // Only edges with ready high move the address and data phases
  always_ff @(posedge clk)
  begin
    cnt_q <= reset ? 32'h0 : cnt_q + 32'h1;
    wr_seen <= 1'b0;
    if (reset)
    begin
      dphase_q <= 1'b0;
    end
    else if (~stall)
    begin
      if (dphase_q)
      begin
        wr_seen <= 1'b1;
        wr_addr <= addr_q;
        wr_data <= m_out.hwdata;
      end
      dphase_q <= m_out.htrans[1];
      addr_q <= m_out.haddr;
    end
  end
endmodule

// ---- test/pab_bridge_tb_top.sv ----
`timescale 1ns/1ps
module pab_bridge_tb_top;
  import pab_pkg::*;
  // window base on a 512KB boundary
  localparam logic [12:0] WB = 13'h0a5;
  logic clk = 0, reset = 1, apb_preset_n = 0, reg_wr = 0, reg_rd = 0, rx_valid = 0;
  logic rx_ready, tx_valid, tx_ready = 0, creg_req, creg_ack = 0, stall = 0, stall_hold = 0;
  logic snk_seen, s_hready, s_hresp, ap_pready, ap_pslverr, creg_err = 0;
  logic [4:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, creg_rdata = '0, snk_a, snk_d, s_hrdata, ap_prdata;
  logic [1:0] ack_sr = '0;
  pab_rx_t rx_word = '0;
  pab_tx_t tx_word;
  pab_creg_t creg_cmd, cmd_seen;
  pab_ahbm_t m_w_out;
  pab_ahbm_in_t m_w_in;
  // lock low, protection and size fixed
  pab_ahbs_in_t s_in = '{hreadyin: 1'b1, hprot: 4'h3, hsize: 3'h2, default: '0};
  pab_apb_in_t ap_in = '0;
  int err_count = 0, n_compared = 0;
  logic [31:0] rs = 32'h6ee2b2a1;
  logic [31:0] base [3];
  logic [63:0] rxq [$];
  logic [32:0] txq [$];

  always #2 clk = ~clk;

  pab_bridge #(.REGISTER_WINDOW_BASE(WB)) pab_bridge_inst (.clk(clk), .reset(reset),
    .ce(1'b1), .apb_preset_n(apb_preset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
    .rx_word(rx_word), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_word(tx_word),
    .tx_ready(tx_ready), .creg_req(creg_req), .creg_cmd(creg_cmd), .creg_ack(creg_ack),
    .creg_err(creg_err), .creg_rdata(creg_rdata), .m_w_out(m_w_out), .m_w_in(m_w_in),
    .m_r_out(), .m_r_in('0), .s_in(s_in), .s_hrdata(s_hrdata), .s_hready(s_hready),
    .s_hresp(s_hresp), .ap_in(ap_in), .ap_prdata(ap_prdata), .ap_pready(ap_pready),
    .ap_pslverr(ap_pslverr));

  pab_ahb_sink pab_ahb_sink_inst (.clk(clk), .reset(reset), .stall(stall), .m_out(m_w_out),
    .m_in(m_w_in), .wr_seen(snk_seen), .wr_addr(snk_a), .wr_data(snk_d));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  // Bounded wait for a level sampled mid-cycle
  task automatic wait_hi(ref logic s);
    @(negedge clk);
    for (int i = 0; i < 64 && s !== 1'b1; i++) @(negedge clk);
  endtask

  task automatic reg_acc(input logic w, input logic [4:0] a, input logic [31:0] d,
                         input logic [31:0] e);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 0;
    @(negedge clk);
    if (!w) chk("reg_rdata", e, reg_rdata);
  endtask

  task automatic rx_pkt(input int k, input int n);
    @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      logic [31:0] d;
      d = rnd();
      rxq.push_back({base[k] + 32'(4 * i), d});
      rx_valid <= 1;
      rx_word <= '{last: i == n - 1, kind: k[1:0], data: d};
      wait_hi(rx_ready);
      @(posedge clk);
    end
    rx_valid <= 0;
  endtask

  task automatic ahb(input logic [31:0] a, input logic e, input logic w = 1'b1);
    logic [31:0] d;
    d = rnd();
    @(posedge clk);
    s_in.hsel <= 1;
    s_in.htrans <= 2'h2;
    s_in.haddr <= a;
    s_in.hwrite <= w;
    wait_hi(s_hready);
    @(posedge clk);
    s_in.hsel <= 0;
    s_in.htrans <= 2'h0;
    s_in.hwdata <= d;
    wait_hi(s_hready);
    chk("s_hresp", e, s_hresp);
    if (!w) chk("s_hrdata", 0, s_hrdata);
    if (!e && w) txq.push_back({a[11:2] == 10'h0, d});
  endtask

  task automatic apb(input logic [31:0] a, input logic e);
    logic [13:0] o;
    logic pw;
    logic [31:0] wd;
    pw = a[2];
    wd = rnd();
    o = a[18:16] == 3'h2 ? {4'h0, a[11:2]} : a[18:16] == 3'h1 ? {8'h0, a[7:2]} : a[15:2];
    @(posedge clk);
    ap_in <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: pw, pwdata: wd};
    @(posedge clk);
    ap_in.penable <= 1;
    wait_hi(ap_pready);
    chk("ap_pslverr", e, ap_pslverr);
    if (!e) chk("creg_cmd", {pw, a[17:16], o}, {cmd_seen.wr, cmd_seen.rgn, cmd_seen.off});
    if (!e && a[18:16] == 3'h2) chk("creg func", a[13:12], cmd_seen.func);
    if (!e && pw) chk("creg wdata", wd, cmd_seen.wdata);
    if (!e && !pw) chk("ap_prdata", {18'h2a5a5, o}, ap_prdata);
    @(posedge clk);
    ap_in <= '0;
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Far side behaviour and monitors
  // ----------------------------------------
  // Random stalls on both streams; the core answers late and refuses the top offset
  always @(posedge clk)
  begin
    void'(rnd());
    stall <= stall_hold | rs[3];
    tx_ready <= rs[9] | rs[1];
    ack_sr <= {ack_sr[0], creg_req};
    creg_ack <= ack_sr[1];
    creg_err <= ack_sr[1] && cmd_seen.off == 14'h3fff;
    creg_rdata <= {18'h2a5a5, cmd_seen.off};
    if (creg_req) cmd_seen <= creg_cmd;
  end

  // Every finished write and every taken word against the model
  always @(posedge clk)
  begin
    if (snk_seen)
    begin
      chk("rx haddr", rxq[0][63:32], snk_a);
      chk("rx hwdata", rxq[0][31:0], snk_d);
      void'(rxq.pop_front());
    end
    if (tx_valid && tx_ready) chk("tx_word", txq.pop_front(), tx_word);
    if (m_w_out.htrans[1]) chk("m_w fixed", {m_w_out.hmastlock, m_w_out.hprot,
      m_w_out.hburst, m_w_out.hsize}, {1'b0, 4'h3, 3'h0, 3'h2});
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 0;
    apb_preset_n <= 1;
    for (int k = 0; k < 3; k++)
    begin
      base[k] = rnd();
      reg_acc(1, 5'(4 * k), base[k], 0);
      base[k][11:0] = 12'h0;
    end
    for (int k = 0; k < 3; k++) reg_acc(0, 5'(4 * k), 0, base[k]);
    reg_acc(0, 5'h14, 0, 0);
    $display("test registers done");
    for (int k = 0; k < 3; k++) rx_pkt(k, 1 + 2 * k);
    stall_hold <= 1;
    fork
      rx_pkt(0, 6);
    join_none
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk("rx_ready full", 0, rx_ready);
    stall_hold <= 0;
    wait fork;
    repeat (40) @(posedge clk);
    chk("rx left", 0, rxq.size());
    $display("test receive done");
    for (int i = 0; i < 4; i++) ahb({WB, 19'h30000} + 32'(4 * i), 0);
    ahb({WB, 19'h30000}, 0);
    ahb({WB, 19'h50000}, 1);
    ahb({WB, 19'h30002}, 1);
    ahb({WB, 19'h31000}, 1);
    ahb({WB + 13'h1, 19'h30000}, 1);
    ahb({WB, 19'h30008}, 0, 0);
    repeat (40) @(posedge clk);
    chk("tx left", 0, txq.size());
    reg_acc(0, 5'h0c, 0, {16'h4, 16'h2});
    reg_acc(0, 5'h10, 0, 0);
    $display("test transmit done");
    for (int i = 0; i < 6; i++)
    begin
      apb({WB, 19'h00000 | 19'(rnd() & 32'h7ffc)}, 0);
      apb({WB, 19'h10000 | 19'(rnd() & 32'hfc)}, 0);
      apb({WB, 19'h20000 | 19'(rnd() & 32'h3ffc)}, 0);
    end
    apb({WB, 19'h10100}, 1);
    apb({WB, 19'h24000}, 1);
    apb({WB, 19'h40000}, 1);
    apb({WB, 19'h00001}, 1);
    apb({WB, 19'h0fffc}, 1);
    @(posedge clk);
    ap_in <= '{paddr: {WB, 19'h70000}, psel: 1'b1, default: '0};
    @(posedge clk);
    ap_in.penable <= 1;
    wait_hi(ap_pready);
    apb_preset_n = 0;
    #1 chk("apb async clear", 0, {ap_pready, ap_pslverr});
    @(posedge clk);
    ap_in <= '0;
    apb_preset_n <= 1;
    apb({WB, 19'h00010}, 0);
    $display("test apb done");
    complete_run();
  end
endmodule
